// file: shared/llp_pkg.sv
// Constants, types and helpers shared by the light-load phase manager.
package llp_pkg;
  // Register map
  localparam logic [7:0] CC_THR_ADDR = 8'hED;
  localparam logic [7:0] CC_THR_RST  = 8'h00;
  // Decoded strap levels of the switching-mode pin
  localparam logic [1:0] STRAP_GND  = 2'h0;
  localparam logic [1:0] STRAP_R68K = 2'h1;
  localparam logic [1:0] STRAP_R33K = 2'h2;
  localparam logic [1:0] STRAP_VCC  = 2'h3;
  // Timing
  localparam int CLK_MHZ       = 100;
  localparam int HOLD_TIME_US  = 1500;
  localparam int BLANK_TIME_US = 200;
  localparam int HOLD_CYCLES   = HOLD_TIME_US * CLK_MHZ;
  localparam int BLANK_CYCLES  = BLANK_TIME_US * CLK_MHZ;
  localparam int SW_DIV_DEF    = 1000;
  localparam logic [3:0] RAMP_STEPS = 4'hF;
  // Phase counts
  localparam logic [2:0] CNT2 = 3'h2;
  localparam logic [2:0] CNT3 = 3'h3;
  localparam logic [2:0] CNT4 = 3'h4;

  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_MID  = 2'h1,
    LVL_HIGH = 2'h2
  } llp_lvl_t;

  // Mask of phases that run for a given active count
  function automatic logic [3:0] llp_mask(input logic [2:0] cnt);
    case (cnt)
      CNT2:    llp_mask = 4'h3;
      CNT3:    llp_mask = 4'h7;
      default: llp_mask = 4'hF;
    endcase
  endfunction
endpackage

// file: src/llp_tick_div.sv
// Divider that makes one switching-cycle enable pulse per period.
`timescale 1ns/100ps
module llp_tick_div #(
  parameter int DIV = llp_pkg::SW_DIV_DEF
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  output logic      o_tick
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_nxt;

  // Count down and pulse when the period wraps
  always_comb begin
    tick_nxt = (cnt_r == 16'h0000);
    cnt_nxt  = tick_nxt ? 16'(DIV - 1) : cnt_r - 16'h0001;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r  <= 16'h0000;
      o_tick <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      o_tick <= tick_nxt;
    end
  end
endmodule

// file: src/llp_duty_ramp.sv
// Duty ramp of a dropping phase: full scale down to zero on switching ticks.
`timescale 1ns/100ps
module llp_duty_ramp (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_tick,
  input  wire logic       i_start,
  input  wire logic       i_abort,
  output logic            o_busy,
  output logic            o_done,
  output logic [3:0]      o_scale
);
  logic [3:0] scale_nxt;
  logic       busy_nxt;
  logic       done_nxt;

  // Abort wins so that a fast add restores full duty at once
  always_comb begin
    scale_nxt = o_scale;
    busy_nxt  = o_busy;
    done_nxt  = 1'b0;
    if (i_abort) begin
      busy_nxt  = 1'b0;
      scale_nxt = llp_pkg::RAMP_STEPS;
    end else if (i_start) begin
      busy_nxt  = 1'b1;
      scale_nxt = llp_pkg::RAMP_STEPS;
    end else if (o_busy && i_tick) begin
      scale_nxt = o_scale - 4'h1;
      if (o_scale == 4'h1) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_scale <= 4'hF;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_scale <= scale_nxt;
      o_busy  <= busy_nxt;
      o_done  <= done_nxt;
    end
  end
endmodule

// file: src/llp_phase_mgr.sv
// Light-load phase manager: mode strap, phase drop/add, drop code, loop select.
`timescale 1ns/100ps
module llp_phase_mgr #(
  parameter int HOLD_CYC  = llp_pkg::HOLD_CYCLES,
  parameter int BLANK_CYC = llp_pkg::BLANK_CYCLES,
  parameter int SW_DIV    = llp_pkg::SW_DIV_DEF
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [1:0]  i_mode_strap,
  input  wire logic        i_master,
  input  wire logic        i_max4,
  input  wire logic        i_tri_driver,
  input  wire logic        i_drop_pin_disabled,
  input  wire logic        i_lvl_hi,
  input  wire logic        i_lvl_lo,
  input  wire logic [3:0]  i_peak_near_limit,
  input  wire logic [3:0]  i_zero_current,
  input  wire logic        i_deep_light,
  input  wire logic        i_cc_ref_reached,
  input  wire logic [1:0]  i_code0_lvl,
  input  wire logic        i_code1,
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  output logic [1:0]       o_code0_lvl,
  output logic             o_code1,
  output logic             o_code_oe_n,
  output logic [3:0]       o_pwm_tri,
  output logic [15:0]      o_duty_scale,
  output logic [3:0]       o_lowside_off,
  output logic [3:0]       o_skip,
  output logic             o_oc_blank,
  output logic             o_cc_loop_active,
  output logic [2:0]       o_cc_ref_code,
  output logic             o_ref_src_en,
  output logic [2:0]       o_active_count
);
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_RAMP = 3'b010,
    ST_HOLD = 3'b100
  } llp_state_t;

  // Analog flags pass two flops; only the second stage is read
  logic [11:0] sync1_r;
  logic [11:0] sync2_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_r <= 12'h000;
      sync2_r <= 12'h000;
    end else begin
      sync1_r <= {i_peak_near_limit, i_zero_current, i_lvl_hi,
                  i_lvl_lo, i_deep_light, i_cc_ref_reached};
      sync2_r <= sync1_r;
    end
  end
  logic [3:0] peak_s;
  logic [3:0] zero_s;
  logic       hi_s;
  logic       lo_s;
  logic       deep_s;
  logic       cc_s;
  assign {peak_s, zero_s, hi_s, lo_s, deep_s, cc_s} = sync2_r;

  logic       tick;
  logic       ramp_busy;
  logic       ramp_done;
  logic [3:0] ramp_scale;
  logic       ramp_start;
  logic       ramp_abort;

  llp_tick_div #(.DIV(SW_DIV)) u_div (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .o_tick    (tick)
  );

  llp_duty_ramp u_ramp (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_tick    (tick),
    .i_start   (ramp_start),
    .i_abort   (ramp_abort),
    .o_busy    (ramp_busy),
    .o_done    (ramp_done),
    .o_scale   (ramp_scale)
  );

  // Strap is caught once after reset release, since it is a static setting
  logic strap_done_r;
  logic de_r;
  logic strap_done_nxt;
  logic de_nxt;
  always_comb begin
    strap_done_nxt = 1'b1;
    de_nxt         = de_r;
    if (!strap_done_r) begin
      de_nxt = (i_mode_strap == llp_pkg::STRAP_GND) ||
               (i_mode_strap == llp_pkg::STRAP_R68K);
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_done_r <= 1'b0;
      de_r         <= 1'b0;
    end else begin
      strap_done_r <= strap_done_nxt;
      de_r         <= de_nxt;
    end
  end

  // Register: constant-current reference code
  logic [7:0] cc_thr_r;
  logic [7:0] cc_thr_nxt;
  logic [7:0] rdata_nxt;
  logic       reg_hit;
  always_comb begin
    reg_hit    = (i_reg_addr == llp_pkg::CC_THR_ADDR);
    cc_thr_nxt = (i_reg_wr && reg_hit) ? i_reg_wdata : cc_thr_r;
    rdata_nxt  = reg_hit ? cc_thr_r : 8'h00; // Unmapped reads give zero
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cc_thr_r    <= llp_pkg::CC_THR_RST;
      o_reg_rdata <= 8'h00;
    end else begin
      cc_thr_r    <= cc_thr_nxt;
      o_reg_rdata <= rdata_nxt;
    end
  end
  assign o_cc_ref_code = cc_thr_r[2:0];

  // Phase count decision
  llp_state_t  state_r;
  llp_state_t  state_nxt;
  logic [2:0]  count_r;
  logic [2:0]  count_nxt;
  logic [17:0] hold_r;
  logic [17:0] hold_nxt;
  logic [14:0] blank_r;
  logic [14:0] blank_nxt;
  logic [2:0]  max_cnt;
  logic [2:0]  target;
  logic [2:0]  slave_cnt;
  logic        drop_ok;
  logic        fast;

  always_comb begin
    max_cnt = i_max4 ? llp_pkg::CNT4 : llp_pkg::CNT3;
    // Pin disable only matters where the decision is made
    drop_ok = strap_done_r && i_tri_driver &&
              (!i_master || !i_drop_pin_disabled);
    if (i_max4) begin
      target = hi_s ? llp_pkg::CNT4 :
               (lo_s ? llp_pkg::CNT3 : llp_pkg::CNT2);
    end else begin
      target = hi_s ? llp_pkg::CNT3 : llp_pkg::CNT2;
    end
    case ({i_code0_lvl, i_code1})
      {llp_pkg::LVL_MID, 1'b1}:  slave_cnt = llp_pkg::CNT4;
      {llp_pkg::LVL_LOW, 1'b1}:  slave_cnt = llp_pkg::CNT3;
      {llp_pkg::LVL_HIGH, 1'b0}: slave_cnt = llp_pkg::CNT2;
      default:                   slave_cnt = max_cnt;
    endcase
    if (slave_cnt > max_cnt) begin
      slave_cnt = max_cnt;
    end
    fast = i_master && drop_ok &&
           (|(peak_s & llp_pkg::llp_mask(count_r))) &&
           ((count_r != max_cnt) || (state_r == ST_RAMP));
  end

  always_comb begin
    state_nxt  = state_r;
    count_nxt  = count_r;
    hold_nxt   = (hold_r != 18'h00000) ? hold_r - 18'h00001 : hold_r;
    blank_nxt  = (blank_r != 15'h0000) ? blank_r - 15'h0001 : blank_r;
    ramp_start = 1'b0;
    ramp_abort = 1'b0;
    if (!drop_ok) begin
      // Everything runs; any ramp in flight is dropped
      state_nxt  = ST_RUN;
      count_nxt  = max_cnt;
      ramp_abort = ramp_busy;
    end else if (!i_master) begin
      state_nxt = ST_RUN;
      count_nxt = slave_cnt;
    end else if (fast) begin
      state_nxt  = ST_HOLD;
      count_nxt  = max_cnt;
      hold_nxt   = 18'(HOLD_CYC);
      blank_nxt  = 15'(BLANK_CYC);
      ramp_abort = (state_r == ST_RAMP);
    end else begin
      case (state_r)
        ST_RUN: begin
          if (target > count_r) begin
            count_nxt = count_r + 3'h1;
          end else if (target < count_r) begin
            state_nxt  = ST_RAMP;
            ramp_start = 1'b1;
          end
        end
        ST_RAMP: begin
          if (target >= count_r) begin
            state_nxt  = ST_RUN;
            ramp_abort = 1'b1;
          end else if (ramp_done) begin
            state_nxt = ST_RUN;
            count_nxt = count_r - 3'h1;
          end
        end
        ST_HOLD: begin
          count_nxt = max_cnt;
          if (hold_r == 18'h00000) begin
            state_nxt = ST_RUN;
          end
        end
        default: begin
          state_nxt = ST_RUN;
          count_nxt = max_cnt;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= ST_RUN;
      count_r <= llp_pkg::CNT4;
      hold_r  <= 18'h00000;
      blank_r <= 15'h0000;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      hold_r  <= hold_nxt;
      blank_r <= blank_nxt;
    end
  end

  // Per-phase outputs, drop code and loop select
  logic [3:0]  tri_nxt;
  logic [15:0] scale_nxt;
  logic [3:0]  lsoff_nxt;
  logic [3:0]  skip_nxt;
  logic [1:0]  code0_nxt;
  logic        code1_nxt;
  logic [3:0]  mask;
  always_comb begin
    mask    = llp_pkg::llp_mask(count_r);
    tri_nxt = drop_ok ? ~mask : 4'h0;
    for (int i = 0; i < 4; i++) begin
      scale_nxt[i*4 +: 4] = mask[i] ? 4'hF : 4'h0;
    end
    // The phase being dropped is always the highest running one
    if (state_r == ST_RAMP) begin
      scale_nxt[(count_r - 3'h1)*4 +: 4] = ramp_scale;
    end
    lsoff_nxt = de_r ? (zero_s & mask) : 4'h0;
    skip_nxt  = (de_r && deep_s) ? mask : 4'h0;
    if (!drop_ok) begin
      code0_nxt = llp_pkg::LVL_LOW;
      code1_nxt = 1'b0;
    end else begin
      case (count_r)
        llp_pkg::CNT2: begin
          code0_nxt = llp_pkg::LVL_HIGH;
          code1_nxt = 1'b0;
        end
        llp_pkg::CNT3: begin
          code0_nxt = llp_pkg::LVL_LOW;
          code1_nxt = 1'b1;
        end
        default: begin
          code0_nxt = llp_pkg::LVL_MID;
          code1_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pwm_tri        <= 4'h0;
      o_duty_scale     <= 16'hFFFF;
      o_lowside_off    <= 4'h0;
      o_skip           <= 4'h0;
      o_code0_lvl      <= llp_pkg::LVL_LOW;
      o_code1          <= 1'b0;
      o_code_oe_n      <= 1'b1;
      o_cc_loop_active <= 1'b0;
      o_ref_src_en     <= 1'b0;
    end else begin
      o_pwm_tri        <= tri_nxt;
      o_duty_scale     <= scale_nxt;
      o_lowside_off    <= lsoff_nxt;
      o_skip           <= skip_nxt;
      o_code0_lvl      <= code0_nxt;
      o_code1          <= code1_nxt;
      o_code_oe_n      <= !i_master;
      o_cc_loop_active <= cc_s;
      o_ref_src_en     <= 1'b1;
    end
  end
  assign o_oc_blank     = (blank_r != 15'h0000);
  assign o_active_count = count_r;

  // Checks
  no_drop_tri_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !drop_ok |=> (o_pwm_tri == 4'h0))
    else $error("tri-state output without drop permission");
  fast_all_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    fast |=> (count_r == $past(max_cnt)) && (state_r == ST_HOLD))
    else $error("fast add did not restore all phases");
  blank_win_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    fast |=> o_oc_blank && (blank_r == 15'(BLANK_CYC)))
    else $error("overcurrent blanking not started");
  hold_keep_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (state_r == ST_HOLD) && drop_ok && i_master && (hold_r != 18'h0)
    |=> count_r == $past(max_cnt))
    else $error("phase dropped during re-enable delay");
  ramp_drop_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_master && $past(drop_ok) && drop_ok && (count_r < $past(count_r))
    |-> $past(ramp_done))
    else $error("phase dropped without a finished ramp");
  add_one_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_master && drop_ok && !fast && (state_r == ST_RUN) && (target > count_r)
    |=> count_r == $past(count_r) + 3'h1)
    else $error("gradual add not one phase");
  slave_three_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_master && drop_ok && (i_code0_lvl == llp_pkg::LVL_LOW) && i_code1
    |=> count_r == llp_pkg::CNT3)
    else $error("slave did not follow three-phase code");
  code_two_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    drop_ok && (count_r == llp_pkg::CNT2)
    |=> (o_code0_lvl == llp_pkg::LVL_HIGH) && !o_code1)
    else $error("two-phase code wrong");
  code_dir_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_master |=> !o_code_oe_n)
    else $error("master not driving code pins");
  de_lowside_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    de_r |=> o_lowside_off == $past(zero_s & mask))
    else $error("diode emulation low-side cut missing");
  cc_select_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    cc_s |=> o_cc_loop_active)
    else $error("current loop not selected at reference");
  reg_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_reg_wr && reg_hit |=> o_cc_ref_code == $past(i_reg_wdata[2:0]))
    else $error("reference code not written");
  cover_fast: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    fast ##1 (state_r == ST_HOLD));
  cover_ramp: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    (state_r == ST_RAMP) ##1 ramp_done);
  cover_slave: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_master && drop_ok && (count_r == llp_pkg::CNT2));
endmodule

// file: sim/llp_partner_model.sv
// Behavioural far side: tri-state FET drivers and the drop-code wires.
`timescale 1ns/100ps
module llp_partner_model (
  input  wire logic [3:0]  i_pwm_tri,
  input  wire logic [15:0] i_duty_scale,
  input  wire logic [1:0]  i_code0_lvl,
  input  wire logic        i_code1,
  input  wire logic        i_code_oe_n,
  input  wire logic [1:0]  i_slv_code0,
  input  wire logic        i_slv_code1,
  output logic [3:0]       o_hs_on,
  output logic [3:0]       o_ls_on,
  output logic [1:0]       o_wire_code0,
  output logic             o_wire_code1
);
  // A mid-level input turns both switches of that phase off
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      o_hs_on[p] = !i_pwm_tri[p] && (i_duty_scale[4*p +: 4] != 4'h0);
      o_ls_on[p] = !i_pwm_tri[p];
    end
  end
  // Master owns the wires while enabled, else the far-side master drives
  assign o_wire_code0 = i_code_oe_n ? i_slv_code0 : i_code0_lvl;
  assign o_wire_code1 = i_code_oe_n ? i_slv_code1 : i_code1;
endmodule

// file: sim/llp_phase_mgr_tb.sv
// Self-checking bench for the light-load phase manager.
`timescale 1ns/100ps
module llp_phase_mgr_tb;
  localparam int HOLD  = 200;
  localparam int BLANK = 50;
  localparam int DIV   = 4;
  localparam int LIMIT = 5000;
  logic        i_clk, i_reset_n, i_master, i_max4, i_tri_driver;
  logic        i_drop_pin_disabled, i_lvl_hi, i_lvl_lo, i_deep_light;
  logic        i_cc_ref_reached, i_reg_wr, code1_w, slv_c1;
  logic [1:0]  i_mode_strap, code0_w, slv_c0;
  logic [3:0]  i_peak_near_limit, i_zero_current, hs_on, ls_on;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [1:0]  o_code0_lvl;
  logic        o_code1, o_code_oe_n, o_oc_blank, o_cc_loop_active;
  logic        o_ref_src_en, de, seen3;
  logic [3:0]  o_pwm_tri, o_lowside_off, o_skip;
  logic [15:0] o_duty_scale;
  logic [2:0]  o_cc_ref_code, o_active_count;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc_n = 0;
  int          i;
  logic [1:0]  c0_tab [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
  logic [2:0]  cnt_tab [4] = '{3'h4, 3'h3, 3'h2, 3'h4};
  logic [3:0]  c1_tab = 4'h3;

  llp_phase_mgr #(.HOLD_CYC(HOLD), .BLANK_CYC(BLANK), .SW_DIV(DIV)) dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_mode_strap(i_mode_strap),
    .i_master(i_master), .i_max4(i_max4), .i_tri_driver(i_tri_driver),
    .i_drop_pin_disabled(i_drop_pin_disabled), .i_lvl_hi(i_lvl_hi),
    .i_lvl_lo(i_lvl_lo), .i_peak_near_limit(i_peak_near_limit),
    .i_zero_current(i_zero_current), .i_deep_light(i_deep_light),
    .i_cc_ref_reached(i_cc_ref_reached), .i_code0_lvl(code0_w),
    .i_code1(code1_w), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_code0_lvl(o_code0_lvl), .o_code1(o_code1),
    .o_code_oe_n(o_code_oe_n), .o_pwm_tri(o_pwm_tri),
    .o_duty_scale(o_duty_scale), .o_lowside_off(o_lowside_off),
    .o_skip(o_skip), .o_oc_blank(o_oc_blank),
    .o_cc_loop_active(o_cc_loop_active), .o_cc_ref_code(o_cc_ref_code),
    .o_ref_src_en(o_ref_src_en), .o_active_count(o_active_count));

  llp_partner_model far (
    .i_pwm_tri(o_pwm_tri), .i_duty_scale(o_duty_scale),
    .i_code0_lvl(o_code0_lvl), .i_code1(o_code1),
    .i_code_oe_n(o_code_oe_n), .i_slv_code0(slv_c0), .i_slv_code1(slv_c1),
    .o_hs_on(hs_on), .o_ls_on(ls_on), .o_wire_code0(code0_w),
    .o_wire_code1(code1_w));

  // Free-running 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Hang guard: a stuck wait ends the run as a failure
  always @(posedge i_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == LIMIT) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Sample just after the edge so that its updates have landed
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_cnt(input logic [2:0] exp, input int lim);
    int k;
    k = 0;
    while (o_active_count !== exp && k < lim) begin
      wt(1);
      k++;
    end
    chk("active_count", 16'(o_active_count), 16'(exp));
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    wt(1);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_reg_addr <= a;
    wt(2);
    chk("reg_rdata", 16'(o_reg_rdata), 16'(exp));
  endtask

  // Reset with a given strap; outputs are checked while reset is held
  task automatic do_reset(input logic [1:0] s);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    i_mode_strap <= s;
    wt(4);
    chk("rst_count", 16'(o_active_count), 16'h4);
    chk("rst_scale", o_duty_scale, 16'hFFFF);
    chk("rst_tri", 16'(o_pwm_tri), 16'h0);
    chk("rst_oe_n", 16'(o_code_oe_n), 16'h1);
    chk("rst_src", 16'(o_ref_src_en), 16'h0);
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    wt(1);
  endtask

  initial begin
    i_reset_n = 1'b0;
    i_mode_strap = 2'h0;
    i_master = 1'b1;
    i_max4 = 1'b1;
    i_tri_driver = 1'b1;
    i_drop_pin_disabled = 1'b1;
    i_lvl_hi = 1'b0;
    i_lvl_lo = 1'b0;
    i_peak_near_limit = 4'h0;
    i_zero_current = 4'hF;
    i_deep_light = 1'b1;
    i_cc_ref_reached = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    slv_c0 = 2'h0;
    slv_c1 = 1'b0;
    // Every strap level: low-side stop and skipping only in diode emulation
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      wt(6);
      de = (s < 2);
      chk("lowside_off", 16'(o_lowside_off), de ? 16'hF : 16'h0);
      chk("skip", 16'(o_skip != 4'h0), 16'(de));
      chk("ref_src_en", 16'(o_ref_src_en), 16'h1);
    end
    // Register: reset value, readback, unmapped place
    reg_rd(8'hED, llp_pkg::CC_THR_RST);
    reg_wr(8'hED, 8'h05);
    chk("cc_ref_code", 16'(o_cc_ref_code), 16'h5);
    reg_wr(8'h10, 8'hAA);
    reg_rd(8'h10, 8'h00);
    reg_rd(8'hED, 8'h05);
    reg_wr(8'hED, 8'hFF);
    reg_rd(8'hED, 8'hFF);
    chk("cc_ref_code", 16'(o_cc_ref_code), 16'h7);
    // Loop selection follows the synchronised reference flag
    @(posedge i_clk);
    i_cc_ref_reached <= 1'b1;
    wt(1);
    chk("cc_sync", 16'(o_cc_loop_active), 16'h0);
    wt(4);
    chk("cc_on", 16'(o_cc_loop_active), 16'h1);
    @(posedge i_clk);
    i_cc_ref_reached <= 1'b0;
    wt(5);
    chk("cc_off", 16'(o_cc_loop_active), 16'h0);
    // Start a drop ramp, then abort it by a fast add
    @(posedge i_clk);
    i_zero_current <= 4'h0;
    i_deep_light <= 1'b0;
    i_drop_pin_disabled <= 1'b0;
    i_lvl_lo <= 1'b1;
    wt(25);
    chk("ramp_scale", 16'(o_duty_scale[15:12] < 4'hF), 16'h1);
    chk("ramp_count", 16'(o_active_count), 16'h4);
    @(posedge i_clk);
    i_peak_near_limit <= 4'h1;
    i = 0;
    while (o_oc_blank !== 1'b1 && i < 10) begin
      wt(1);
      i++;
    end
    i = 0;
    while (o_oc_blank === 1'b1 && i < 100) begin
      wt(1);
      i++;
    end
    chk("blank_len", 16'(i), 16'(BLANK));
    @(posedge i_clk);
    i_peak_near_limit <= 4'h0;
    wt(1);
    chk("abort_scale", o_duty_scale, 16'hFFFF);
    chk("fast_count", 16'(o_active_count), 16'h4);
    wt(90);
    chk("hold_count", 16'(o_active_count), 16'h4);
    wait_cnt(3'h3, 250);
    // Per-phase outputs and code pins are registered from the count
    wt(1);
    chk("tri3", 16'(o_pwm_tri), 16'h8);
    chk("sw_on3", 16'(hs_on | ls_on), 16'h7);
    chk("code0_3", 16'(o_code0_lvl), 16'(llp_pkg::LVL_LOW));
    chk("code1_3", 16'(o_code1), 16'h1);
    chk("oe_n_m", 16'(o_code_oe_n), 16'h0);
    @(posedge i_clk);
    i_lvl_lo <= 1'b0;
    wait_cnt(3'h2, 100);
    wt(1);
    chk("tri2", 16'(o_pwm_tri), 16'hC);
    chk("code0_2", 16'(o_code0_lvl), 16'(llp_pkg::LVL_HIGH));
    chk("code1_2", 16'(o_code1), 16'h0);
    // Gradual add: one phase per step, no ramp
    @(posedge i_clk);
    i_lvl_hi <= 1'b1;
    i_lvl_lo <= 1'b1;
    seen3 = 1'b0;
    for (int k = 0; k < 10; k++) begin
      wt(1);
      seen3 = seen3 | (o_active_count === 3'h3);
    end
    chk("add_step", 16'(seen3), 16'h1);
    chk("add_count", 16'(o_active_count), 16'h4);
    chk("add_scale", o_duty_scale, 16'hFFFF);
    chk("code0_4", 16'(o_code0_lvl), 16'(llp_pkg::LVL_MID));
    chk("code1_4", 16'(o_code1), 16'h1);
    // Three-phase maximum
    @(posedge i_clk);
    i_max4 <= 1'b0;
    wait_cnt(3'h3, 100);
    @(posedge i_clk);
    i_lvl_hi <= 1'b0;
    i_lvl_lo <= 1'b0;
    wait_cnt(3'h2, 100);
    @(posedge i_clk);
    i_lvl_hi <= 1'b1;
    wait_cnt(3'h3, 10);
    // Disabled dropping forces the maximum count
    @(posedge i_clk);
    i_max4 <= 1'b1;
    i_lvl_hi <= 1'b0;
    i_drop_pin_disabled <= 1'b1;
    wait_cnt(3'h4, 10);
    chk("code_dis", 16'({o_code0_lvl, o_code1}), 16'h0);
    @(posedge i_clk);
    i_drop_pin_disabled <= 1'b0;
    i_tri_driver <= 1'b0;
    wt(150);
    chk("notri_cnt", 16'(o_active_count), 16'h4);
    chk("notri_tri", 16'(o_pwm_tri), 16'h0);
    // Slave follows every code and makes no decision of its own
    @(posedge i_clk);
    i_master <= 1'b0;
    i_tri_driver <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      slv_c0 <= c0_tab[k];
      slv_c1 <= c1_tab[k];
      wt(5);
      chk("slave_count", 16'(o_active_count), 16'(cnt_tab[k]));
    end
    chk("oe_n_s", 16'(o_code_oe_n), 16'h1);
    end_sim();
  end
endmodule
